/* File: verilog/timer_pkg.sv */
// constants of the match/capture timer: register map, field layout, reset values
// assumes a 32-bit classic wishbone slave port with byte addresses
package timer_pkg;

    // ==========================================================
    // sizes
    localparam int DW = 32;
    localparam int NUM_MATCH = 4;
    localparam int NUM_CAP = 2;
    localparam int NUM_DMA = 2;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_PRESC = 8'h08;
    localparam logic [7:0] OFS_PCNT = 8'h0c;
    localparam logic [7:0] OFS_MCTRL = 8'h10;
    localparam logic [7:0] OFS_MATCH [NUM_MATCH] = '{8'h14, 8'h18, 8'h1c, 8'h20};
    localparam logic [7:0] OFS_CCTRL = 8'h24;
    localparam logic [7:0] OFS_CAP [NUM_CAP] = '{8'h28, 8'h2c};
    localparam logic [7:0] OFS_OCTRL = 8'h30;
    localparam logic [7:0] OFS_DMA = 8'h34;
    localparam logic [7:0] OFS_STAT = 8'h38;
    localparam logic [7:0] OFS_MASK = 8'h3c;

    // ==========================================================
    // field positions
    localparam int CTRL_EN = 0;     // counting enabled
    localparam int CTRL_RST = 1;    // hold count and prescaler count at zero
    localparam int CTRL_MODE = 2;   // 0 timer, 1 external counter
    localparam int CTRL_CRISE = 3;  // counter mode: count rising edges
    localparam int CTRL_CFALL = 4;  // counter mode: count falling edges
    localparam int CTRL_W = 5;
    localparam int MC_INT = 0;      // per match: flag event
    localparam int MC_RST = 1;      // per match: zero the count
    localparam int MC_STOP = 2;     // per match: halt counting
    localparam int MC_STRIDE = 3;
    localparam int CC_RISE = 0;     // per capture: rising edge
    localparam int CC_FALL = 1;     // per capture: falling edge
    localparam int CC_INT = 2;      // per capture: flag event
    localparam int CC_STRIDE = 3;
    localparam int OC_STRIDE = 2;   // output action per match
    localparam int OC_VAL = 8;      // output levels, read only
    localparam int ST_MATCH = 0;    // status: match flags
    localparam int ST_CAP = 4;      // status: capture flags
    localparam int ST_W = 6;

    // ==========================================================
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
    localparam logic [DW-1:0] WORD_RESET = 32'h0000_0000;
    localparam logic [ST_W-1:0] STAT_RESET = 6'h00;

    // ==========================================================
    // output action on match
    typedef enum logic [1:0] {
        ACT_NONE = 2'h0,
        ACT_LOW = 2'h1,
        ACT_HIGH = 2'h2,
        ACT_TOGGLE = 2'h3
    } out_act_t;

endpackage

/* File: verilog/edge_if.sv */
// carrier between the timer core and its edge detector
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface edge_if #(parameter int N_CAP = 2);
    logic [N_CAP-1:0] cap_in;
    logic [N_CAP-1:0] cap_rise;
    logic [N_CAP-1:0] cap_fall;
    logic [N_CAP-1:0] cap_evt;
    logic cnt_in;
    logic cnt_rise;
    logic cnt_fall;
    logic cnt_tick;

    modport core (output cap_in, cap_rise, cap_fall, cnt_in, cnt_rise, cnt_fall, input cap_evt, cnt_tick);
    modport det (input cap_in, cap_rise, cap_fall, cnt_in, cnt_rise, cnt_fall, output cap_evt, cnt_tick);
endinterface

/* File: verilog/edge_detect.sv */
// edge detector for the capture inputs and the external count input
// assumes inputs already synchronous to clk_i
`timescale 1ns/10ps
module edge_detect #(
    parameter int N_CAP = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // link to core
    edge_if.det e
);
    logic [N_CAP-1:0] cap_prev_q;
    logic cnt_prev_q;

    // ==========================================================
    // previous input levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_prev_q <= '0;
            cnt_prev_q <= 1'b0;
        end else begin
            cap_prev_q <= e.cap_in;
            cnt_prev_q <= e.cnt_in;
        end
    end

    // ==========================================================
    // selected edges per channel
    for (genvar i = 0; i < N_CAP; i++) begin : g_cap
        assign e.cap_evt[i] = (e.cap_rise[i] & ~cap_prev_q[i] & e.cap_in[i])
                            | (e.cap_fall[i] & cap_prev_q[i] & ~e.cap_in[i]);
    end

    assign e.cnt_tick = (e.cnt_rise & ~cnt_prev_q & e.cnt_in) | (e.cnt_fall & cnt_prev_q & ~e.cnt_in);
endmodule

/* File: verilog/match_capture_timer.sv */
// match/capture timer with prescaler, wishbone register port and one interrupt line
// assumes classic wishbone master on clk_i, pins synchronous to clk_i
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
module match_capture_timer
    import timer_pkg::*;
#(
    parameter int N_CAP = NUM_CAP
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DW-1:0] wb_dat_i,
    output logic [DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    // pins
    input wire logic count_in_i,
    input wire logic [N_CAP-1:0] cap_in_i,
    output logic [NUM_MATCH-1:0] match_out_o,
    output logic [NUM_DMA-1:0] dma_req_o,
    output logic irq_o
);

    // ==========================================================
    // state
    logic ack_q;
    logic [DW-1:0] dat_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [DW-1:0] count_q;
    logic [DW-1:0] presc_q;
    logic [DW-1:0] pcnt_q;
    logic [NUM_MATCH*MC_STRIDE-1:0] mctrl_q;
    logic [DW-1:0] match_q [NUM_MATCH];
    logic [N_CAP*CC_STRIDE-1:0] cctrl_q;
    logic [DW-1:0] cap_q [N_CAP];
    logic [NUM_MATCH*OC_STRIDE-1:0] octrl_q;
    logic [NUM_DMA-1:0] dma_q;
    logic [ST_W-1:0] stat_q;
    logic [ST_W-1:0] mask_q;
    logic [NUM_MATCH-1:0] mout_q;
    logic [NUM_DMA-1:0] dma_req_q;

    // ==========================================================
    // bus decode
    logic req;
    logic wr;
    logic rd_done;
    logic [DW-1:0] rdata;
    logic [DW-1:0] wmerged;
    logic [ST_W-1:0] stat_clr;
    logic [ST_W-1:0] stat_set;

    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & ack_q;        // write lands on the acked edge
    assign rd_done = req & ~wb_we_i & ack_q;
    assign wmerged = merge(rdata, wb_dat_i, wb_sel_i);  // lanes over the addressed register

    // byte-lane merge of a write
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v, input logic [DW-1:0] new_v,
                                            input logic [3:0] sel);
        logic [DW-1:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // one-cycle ack, dropped after each answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // read data captured while the request waits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= WORD_RESET;
        end else if (req & ~ack_q) begin
            dat_q <= rdata;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // read mux, unmapped reads as zero
    always_comb begin
        rdata = WORD_RESET;
        unique case (wb_adr_i)
            OFS_CTRL: rdata[CTRL_W-1:0] = ctrl_q;
            OFS_COUNT: rdata = count_q;
            OFS_PRESC: rdata = presc_q;
            OFS_PCNT: rdata = pcnt_q;
            OFS_MCTRL: rdata[NUM_MATCH*MC_STRIDE-1:0] = mctrl_q;
            OFS_CCTRL: rdata[N_CAP*CC_STRIDE-1:0] = cctrl_q;
            OFS_OCTRL: rdata = {20'h0_0000, mout_q, octrl_q};
            OFS_DMA: rdata[NUM_DMA-1:0] = dma_q;
            OFS_STAT: rdata[ST_W-1:0] = stat_q;
            OFS_MASK: rdata[ST_W-1:0] = mask_q;
            default: rdata = WORD_RESET;
        endcase
        for (int i = 0; i < NUM_MATCH; i++) begin
            if (wb_adr_i == OFS_MATCH[i]) begin
                rdata = match_q[i];
            end
        end
        for (int i = 0; i < N_CAP; i++) begin
            if (wb_adr_i == OFS_CAP[i]) begin
                rdata = cap_q[i];
            end
        end
    end

    // ==========================================================
    // edge detector
    edge_if #(.N_CAP(N_CAP)) eif ();

    assign eif.cap_in = cap_in_i;
    assign eif.cnt_in = count_in_i;
    assign eif.cnt_rise = ctrl_q[CTRL_CRISE];
    assign eif.cnt_fall = ctrl_q[CTRL_CFALL];
    for (genvar i = 0; i < N_CAP; i++) begin : g_csel
        assign eif.cap_rise[i] = cctrl_q[i*CC_STRIDE+CC_RISE];
        assign eif.cap_fall[i] = cctrl_q[i*CC_STRIDE+CC_FALL];
    end

    edge_detect #(.N_CAP(N_CAP)) u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .e(eif.det)
    );

    // ==========================================================
    // count path
    logic run;
    logic ptick;
    logic inc;
    logic [NUM_MATCH-1:0] hit;
    logic [NUM_MATCH-1:0] hit_rst;
    logic [NUM_MATCH-1:0] hit_stop;
    logic any_rst;
    logic any_stop;

    assign run = ctrl_q[CTRL_EN] & ~ctrl_q[CTRL_RST];
    assign ptick = run & (ctrl_q[CTRL_MODE] ? eif.cnt_tick : 1'b1);
    assign inc = ptick & (pcnt_q == presc_q);

    // compare each match on a count step
    for (genvar i = 0; i < NUM_MATCH; i++) begin : g_hit
        assign hit[i] = inc & (count_q == match_q[i]);
        assign hit_rst[i] = hit[i] & mctrl_q[i*MC_STRIDE+MC_RST];
        assign hit_stop[i] = hit[i] & mctrl_q[i*MC_STRIDE+MC_STOP];
    end
    assign any_rst = |hit_rst;
    assign any_stop = |hit_stop;

    // control word; stop match clears enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr && wb_adr_i == OFS_CTRL) begin
            ctrl_q <= wmerged[CTRL_W-1:0];
        end else if (any_stop) begin
            ctrl_q[CTRL_EN] <= 1'b0;
        end
    end

    // count register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= WORD_RESET;
        end else if (wr && wb_adr_i == OFS_COUNT) begin
            count_q <= merge(count_q, wb_dat_i, wb_sel_i);
        end else if (ctrl_q[CTRL_RST]) begin
            count_q <= WORD_RESET;
        end else if (inc && !any_stop) begin
            // zero on reset match, else keep counting
            count_q <= any_rst ? WORD_RESET : count_q + 32'h0000_0001;
        end
    end

    // prescaler register and its running count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc_q <= WORD_RESET;
        end else if (wr && wb_adr_i == OFS_PRESC) begin
            presc_q <= merge(presc_q, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pcnt_q <= WORD_RESET;
        end else if (ctrl_q[CTRL_RST] || inc) begin
            pcnt_q <= WORD_RESET;
        end else if (ptick) begin
            pcnt_q <= pcnt_q + 32'h0000_0001;
        end
    end

    // ==========================================================
    // match, capture and output configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mctrl_q <= '0;
            cctrl_q <= '0;
            octrl_q <= '0;
            dma_q <= '0;
            mask_q <= STAT_RESET;
        end else if (wr) begin
            if (wb_adr_i == OFS_MCTRL) mctrl_q <= wmerged[NUM_MATCH*MC_STRIDE-1:0];
            if (wb_adr_i == OFS_CCTRL) cctrl_q <= wmerged[N_CAP*CC_STRIDE-1:0];
            if (wb_adr_i == OFS_OCTRL) octrl_q <= wmerged[NUM_MATCH*OC_STRIDE-1:0];
            if (wb_adr_i == OFS_DMA) dma_q <= wmerged[NUM_DMA-1:0];
            if (wb_adr_i == OFS_MASK) mask_q <= wmerged[ST_W-1:0];
        end
    end

    // match values and capture snapshots
    for (genvar i = 0; i < NUM_MATCH; i++) begin : g_mreg
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                match_q[i] <= WORD_RESET;
            end else if (wr && wb_adr_i == OFS_MATCH[i]) begin
                match_q[i] <= merge(match_q[i], wb_dat_i, wb_sel_i);
            end
        end
    end

    for (genvar i = 0; i < N_CAP; i++) begin : g_cap
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cap_q[i] <= WORD_RESET;
            end else if (eif.cap_evt[i]) begin
                cap_q[i] <= count_q;
            end
        end
    end

    // ==========================================================
    // match outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mout_q <= '0;
        end else begin
            for (int i = 0; i < NUM_MATCH; i++) begin
                if (hit[i]) begin
                    unique case (out_act_t'(octrl_q[i*OC_STRIDE +: OC_STRIDE]))
                        ACT_NONE: mout_q[i] <= mout_q[i];
                        ACT_LOW: mout_q[i] <= 1'b0;
                        ACT_HIGH: mout_q[i] <= 1'b1;
                        ACT_TOGGLE: mout_q[i] <= ~mout_q[i];
                    endcase
                end
            end
        end
    end
    assign match_out_o = mout_q;

    // one-cycle dma request per enabled match, matches 0 and 1 only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_req_q <= '0;
        end else begin
            dma_req_q <= hit[NUM_DMA-1:0] & dma_q;
        end
    end
    assign dma_req_o = dma_req_q;

    // ==========================================================
    // interrupt status
    for (genvar i = 0; i < NUM_MATCH; i++) begin : g_sm
        assign stat_set[ST_MATCH+i] = hit[i] & mctrl_q[i*MC_STRIDE+MC_INT];
    end
    for (genvar i = 0; i < N_CAP; i++) begin : g_sc
        assign stat_set[ST_CAP+i] = eif.cap_evt[i] & cctrl_q[i*CC_STRIDE+CC_INT];
    end

    // cleared by writing one, or by reading bits that were returned
    always_comb begin
        stat_clr = '0;
        if (wr && wb_adr_i == OFS_STAT) stat_clr = wb_dat_i[ST_W-1:0];
        if (rd_done && wb_adr_i == OFS_STAT) stat_clr = dat_q[ST_W-1:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= STAT_RESET;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end
    assign irq_o = |(stat_q & mask_q);

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic wr_any;
    assign wr_any = req & wb_we_i;

    sequence seq_halted;
        !ctrl_q[CTRL_EN] && $stable(count_q);
    endsequence

    chk_count_cause: assert property (
        !$stable(count_q) |-> $past(inc) || $past(wr_any) || $past(ctrl_q[CTRL_RST]))
        else $error("count moved without a prescaler wrap");
    chk_timer_mode: assert property (
        run && !ctrl_q[CTRL_MODE] && presc_q == 32'h0 && !any_stop && !any_rst && !wr_any
        |=> count_q == $past(count_q) + 32'h1)
        else $error("timer mode did not count each cycle");
    chk_cap_load: assert property (
        eif.cap_evt[0] |=> cap_q[0] == $past(count_q))
        else $error("capture did not take the count");
    chk_match_cmp: assert property (
        hit[1] |-> count_q == match_q[1] && pcnt_q == presc_q && run)
        else $error("match without equal count");
    chk_match_cont: assert property (
        hit[0] && !any_stop && !any_rst && !wr_any |=> count_q == $past(count_q) + 32'h1)
        else $error("plain match disturbed the count");
    chk_match_stop: assert property (
        any_stop && !wr_any |=> seq_halted ##1 (!ctrl_q[CTRL_EN] || $past(wr_any)))
        else $error("stop match did not halt");
    chk_match_reset: assert property (
        any_rst && !any_stop && !wr_any |=> count_q == 32'h0)
        else $error("reset match did not zero the count");
    chk_out_toggle: assert property (
        hit[0] && octrl_q[1:0] == ACT_TOGGLE |=> match_out_o[0] != $past(match_out_o[0]))
        else $error("toggle action missed");
    chk_dma_pulse: assert property (
        hit[0] && dma_q[0] |=> dma_req_o[0])
        else $error("dma request missing after match");
    chk_cap_edge: assert property (
        eif.cap_evt[0] |-> (cctrl_q[CC_RISE] && $rose(cap_in_i[0])) || (cctrl_q[CC_FALL] && $fell(cap_in_i[0])))
        else $error("capture on an unselected edge");
    chk_irq_flag: assert property (
        stat_set[0] ##1 mask_q[0] |-> stat_q[0] && irq_o)
        else $error("flagged match did not interrupt");

endmodule

/* File: test/tb.sv */
// self-checking bench of the match/capture timer, register rows then hand-written cases
// assumes timer_pkg and all design files compiled before it
`timescale 1ns/10ps
module tb;
    import timer_pkg::*;
    // ==========================================================
    // signals
    typedef struct {logic [7:0] adr; logic [31:0] wd; logic [31:0] rd;} row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic count_in_i = 1'b0;
    logic [1:0] cap_in_i = 2'h0;
    logic [3:0] match_out_o;
    logic [1:0] dma_req_o;
    logic irq_o;
    logic [31:0] v;
    logic o;
    int n;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int dma0_n = 0;
    int dma1_n = 0;
    row_t rows [12];

    always #5 clk_i = ~clk_i;

    match_capture_timer match_capture_timer_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .count_in_i(count_in_i),
        .cap_in_i(cap_in_i), .match_out_o(match_out_o), .dma_req_o(dma_req_o), .irq_o(irq_o));

    // ==========================================================
    // compare, bus and pin tasks
    task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk1(input string nm, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", nm, exp, got);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        chk1("ack", 1'b1, wb_ack_o);
        v = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_cycle(1'b1, a, d, 4'hf);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        wb_cycle(1'b0, a, 32'h0, 4'hf);
        chk32(nm, exp, v);
    endtask

    // edges until the next match 0 request pulse
    task automatic wait_dma0();
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (dma_req_o[0] !== 1'b1 && n < 100);
    endtask

    task automatic pulse_cnt(input int k);
        repeat (k) begin
            @(posedge clk_i);
            count_in_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            count_in_i <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // request pulse counters and hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (dma_req_o[0] === 1'b1) dma0_n++;
        if (dma_req_o[1] === 1'b1) dma1_n++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        rows = '{'{OFS_PRESC, 32'hffff_ffff, 32'hffff_ffff}, '{OFS_MATCH[0], 32'h100, 32'h100},
            '{OFS_MATCH[1], 32'h200, 32'h200}, '{OFS_MATCH[2], 32'h300, 32'h300},
            '{OFS_MATCH[3], 32'h400, 32'h400}, '{OFS_PCNT, 32'h1234, 32'h0}, '{OFS_CAP[1], 32'h1234, 32'h0},
            '{8'h40, 32'hffff, 32'h0}, '{OFS_MCTRL, 32'hfff, 32'hfff}, '{OFS_CCTRL, 32'h3f, 32'h3f},
            '{OFS_DMA, 32'h3, 32'h3}, '{OFS_CTRL, 32'h1e, 32'h1e}};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // reset values, then write and read back each row
        foreach (rows[i]) rd(rows[i].adr, 32'h0, "reset_value");
        rd(OFS_STAT, 32'h0, "reset_stat");
        foreach (rows[i]) begin
            wr(rows[i].adr, rows[i].wd);
            rd(rows[i].adr, rows[i].rd, "row_readback");
        end
        wb_cycle(1'b1, OFS_PRESC, 32'h0, 4'h2);
        rd(OFS_PRESC, 32'hffff_00ff, "presc_lanes");
        // reset match: period, request pulse, toggle, interrupt
        wr(OFS_PRESC, 32'h1);
        wr(OFS_MATCH[0], 32'h3);
        wr(OFS_MCTRL, 32'h3);
        wr(OFS_OCTRL, 32'h3);
        wr(OFS_DMA, 32'h1);
        wr(OFS_MASK, 32'h1);
        wr(OFS_CTRL, 32'h1);
        wait_dma0();
        wait_dma0();
        chk32("reset_period", 32'd8, n);
        chk1("irq_match", 1'b1, irq_o);
        o = match_out_o[0];
        wait_dma0();
        chk1("toggle", ~o, match_out_o[0]);
        wb_cycle(1'b0, OFS_COUNT, 32'h0, 4'hf);
        chk1("count_bound", 1'b1, v <= 32'd3);
        // stop via hold reset, so the prescaler count is zero before it shrinks
        wr(OFS_CTRL, 32'h2);
        rd(OFS_STAT, 32'h1, "stat_match");
        rd(OFS_STAT, 32'h0, "stat_read_clear");
        @(negedge clk_i);
        chk1("irq_clear", 1'b0, irq_o);
        // stop match with continuous match before it
        wr(OFS_COUNT, 32'h0);
        wr(OFS_PRESC, 32'h0);
        wr(OFS_MATCH[1], 32'h5);
        wr(OFS_MATCH[2], 32'h2);
        wr(OFS_MCTRL, 32'h68);
        wr(OFS_OCTRL, 32'h9);
        wr(OFS_DMA, 32'h2);
        dma0_n = 0;
        dma1_n = 0;
        wr(OFS_CTRL, 32'h1);
        repeat (30) @(posedge clk_i);
        rd(OFS_COUNT, 32'h5, "stop_count");
        rd(OFS_CTRL, 32'h0, "stop_enable");
        rd(OFS_STAT, 32'h6, "stat_flags");
        rd(OFS_OCTRL, 32'h209, "out_levels");
        chk32("out_pins", 32'h2, {28'h0, match_out_o});
        chk32("dma1_pulses", 32'd1, dma1_n);
        chk32("dma0_pulses", 32'd0, dma0_n);
        chk1("irq_masked", 1'b0, irq_o);
        // capture edges, flag, mask and write-one clear
        wr(OFS_COUNT, 32'h77);
        wr(OFS_CCTRL, 32'h15);
        wr(OFS_MASK, 32'h20);
        @(posedge clk_i);
        cap_in_i <= 2'b01;
        repeat (3) @(posedge clk_i);
        cap_in_i <= 2'b00;
        repeat (3) @(posedge clk_i);
        wr(OFS_COUNT, 32'h88);
        @(posedge clk_i);
        cap_in_i <= 2'b10;
        repeat (3) @(posedge clk_i);
        rd(OFS_CAP[1], 32'h0, "cap1_rise_ignored");
        @(posedge clk_i);
        cap_in_i <= 2'b00;
        repeat (3) @(posedge clk_i);
        rd(OFS_CAP[0], 32'h77, "cap0");
        rd(OFS_CAP[1], 32'h88, "cap1");
        @(negedge clk_i);
        chk1("irq_cap1_unflagged", 1'b0, irq_o);
        wr(OFS_MASK, 32'h10);
        @(negedge clk_i);
        chk1("irq_cap0", 1'b1, irq_o);
        wr(OFS_STAT, 32'h10);
        @(negedge clk_i);
        chk1("irq_write_clear", 1'b0, irq_o);
        // counter operation on rising, then both edges
        wr(OFS_MCTRL, 32'h0);
        wr(OFS_COUNT, 32'h0);
        wr(OFS_CTRL, 32'hd);
        pulse_cnt(3);
        rd(OFS_COUNT, 32'h3, "count_rise");
        wr(OFS_CTRL, 32'h1d);
        wr(OFS_COUNT, 32'h0);
        pulse_cnt(2);
        rd(OFS_COUNT, 32'h4, "count_both");
        // reset in mid-run, with a capture flag pending
        wr(OFS_MASK, 32'h3f);
        @(posedge clk_i);
        cap_in_i <= 2'b01;
        repeat (2) @(posedge clk_i);
        chk1("irq_before_reset", 1'b1, irq_o);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk1("irq_after_reset", 1'b0, irq_o);
        rd(OFS_CTRL, 32'h0, "ctrl_after_reset");
        rd(OFS_COUNT, 32'h0, "count_after_reset");
        rd(OFS_MASK, 32'h0, "mask_after_reset");
        print_verdict();
    end
endmodule
